// ==== include/cpsr_defs.vh ====
// register map, field positions, reset values and control port framing for the power sequencer
`ifndef CPSR_DEFS_VH
`define CPSR_DEFS_VH

// register addresses (7-bit)
`define CPSR_ADDR_SOFT_RESET   7'h00
`define CPSR_ADDR_POWER_ONE    7'h01
`define CPSR_ADDR_POWER_TWO    7'h02
`define CPSR_ADDR_POWER_THREE  7'h03
`define CPSR_ADDR_CLOCK_CTRL   7'h06
`define CPSR_ADDR_DAC_CTRL     7'h0A
`define CPSR_ADDR_ADC_CTRL     7'h0E
`define CPSR_ADDR_BOOST_CTRL   7'h2F
`define CPSR_ADDR_POWER_STATUS 7'h2E
`define CPSR_ADDR_LOW_POWER    7'h3A

// reset values (9-bit)
`define CPSR_RST_POWER_ONE     9'h000
`define CPSR_RST_POWER_TWO     9'h000
`define CPSR_RST_POWER_THREE   9'h000
`define CPSR_RST_CLOCK_CTRL    9'h140
`define CPSR_RST_DAC_CTRL      9'h000
`define CPSR_RST_ADC_CTRL      9'h100
`define CPSR_RST_BOOST_CTRL    9'h000
`define CPSR_RST_LOW_POWER     9'h000

// writable bit masks; other bits read as zero
`define CPSR_MASK_POWER_ONE    9'h17F
`define CPSR_MASK_POWER_TWO    9'h015
`define CPSR_MASK_POWER_THREE  9'h0ED
`define CPSR_MASK_CLOCK_CTRL   9'h1FD
`define CPSR_MASK_DAC_CTRL     9'h07D
`define CPSR_MASK_ADC_CTRL     9'h1F9
`define CPSR_MASK_BOOST_CTRL   9'h00C
`define CPSR_MASK_LOW_POWER    9'h1FF

// power register one fields
`define CPSR_REF_IMPEDANCE_SEL_LSB        0
`define CPSR_BIASBUF_BIT       2
`define CPSR_MBIAS_BIT         3
`define CPSR_MICBIAS_BIT       4
`define CPSR_PLL_BIT           5
`define CPSR_AUX_BIT           6
`define CPSR_DCBUF_BIT         8
// power register two fields
`define CPSR_ADC_EN_BIT        0
`define CPSR_PGA_EN_BIT        2
`define CPSR_BOOSTSTG_EN_BIT   4
// power register three fields
`define CPSR_DAC_EN_BIT        0
`define CPSR_SPKMIX_BIT        2
`define CPSR_MONOMIX_BIT       3
`define CPSR_SPKPOS_BIT        5
`define CPSR_SPKNEG_BIT        6
`define CPSR_MONOOUT_BIT       7
// clock control fields
`define CPSR_CLKIO_BIT         0
`define CPSR_BCLKDIV_LSB       2
`define CPSR_MCLKDIV_LSB       5
// converter control fields
`define CPSR_OSR_BIT           3
`define CPSR_DAC_MUTE_BIT      6
// boost control fields
`define CPSR_SPK_BOOST_BIT     2
`define CPSR_MONO_BOOST_BIT    3

// control port frame: read flag, 7 address bits, 9 data bits
`define CPSR_FRAME_BITS        5'd17
`define CPSR_HEAD_BITS         5'd8
`endif

// ==== logic/cpsr_power_seq.v ====
// codec power sequencing registers behind a serial control port
// Operation
// - master bias bit powers all analog bias
// - two-bit field selects reference resistor value
// - oversample bits: low 64x, high 128x
// - every analog function has own enable bit
// - bias buffer bit turns on buffer
`timescale 1ns/100ps
`default_nettype none
`include "cpsr_defs.vh"

module cpsr_power_seq
(
  input  wire       clk,                  // 40 MHz system clock
  input  wire       rst,                  // asynchronous reset, active high
  input  wire       ctl_sclk,             // control port serial clock
  input  wire       ctl_cs_n,             // control port frame select, active low
  input  wire       ctl_sdin,             // control port serial data in
  output wire       ctl_sdout,            // readback data
  output wire       ctl_sdout_oe,         // readback drive enable
  output reg  [1:0] ref_impedance_sel,    // reference resistor select
  output reg        master_bias_en,       // analog bias for all blocks
  output reg        bias_buffer_en,       // internal bias buffer
  output reg        mic_bias_en,          // microphone bias
  output reg        aux_en,               // auxiliary input
  output reg        dc_buffer_en,         // dc buffer
  output reg        pll_power_en,         // pll power
  output reg        adc_power_en,         // adc power
  output reg        pga_power_en,         // input gain stage power
  output reg        input_boost_en,       // input boost stage power
  output reg        dac_power_en,         // dac power
  output reg        speaker_mixer_en,     // speaker mixer power
  output reg        mono_mixer_en,        // mono mixer power
  output reg        speaker_pos_en,       // speaker positive driver
  output reg        speaker_neg_en,       // speaker negative driver
  output reg        mono_output_en,       // mono output driver
  output reg        clock_io_master_en,   // clock pins driven as master
  output reg  [2:0] bit_clock_div_sel,    // bit clock divider
  output reg  [2:0] master_clock_div_sel, // master clock divider
  output reg        dac_oversample_sel,   // 0: 64x, 1: 128x
  output reg        adc_oversample_sel,   // 0: 64x, 1: 128x
  output reg        dac_soft_mute,        // dac mute
  output reg        speaker_boost_mode,   // 5.0 V speaker mode
  output reg        mono_out_boost_mode,  // 5.0 V mono mode
  output reg  [8:0] low_power_bits        // low power control field
);

  reg  [8:0] power_reg_one;         // power register one
  reg  [8:0] power_two_reg;         // power register two
  reg  [8:0] power_three_reg;       // power register three
  reg  [8:0] clock_ctrl_reg;        // clock control
  reg  [8:0] dac_control_reg;       // dac control
  reg  [8:0] adc_control_reg;       // adc control
  reg  [8:0] boost_ctrl_reg;        // speaker supply mode
  reg  [8:0] low_power_reg;         // low power control
  reg        sclk_last_reg;         // sclk one cycle ago
  reg  [4:0] bit_count_reg;         // bits taken in this frame
  reg  [7:0] head_reg;              // read flag and address
  reg  [8:0] wdata_reg;             // write data shift
  reg  [8:0] rdata_reg;             // readback shift
  reg        reading_reg;           // frame is a read
  wire       sclk_rise;             // sample edge
  wire       sclk_fall;             // shift-out edge
  wire       write_now;             // last data bit taken
  wire [8:0] write_word;            // full write word
  wire [6:0] write_addr;            // write address
  wire [8:0] status_word;           // effective power state

  // effective enables: nothing is powered without master bias
  assign status_word = {master_bias_en & dc_buffer_en,
                        master_bias_en & mono_output_en,
                        master_bias_en & (speaker_neg_en | speaker_pos_en),
                        master_bias_en & (speaker_mixer_en | mono_mixer_en),
                        master_bias_en & dac_power_en,
                        master_bias_en & adc_power_en,
                        master_bias_en & pll_power_en,
                        master_bias_en & bias_buffer_en,
                        master_bias_en};

  // register readback by address; unmapped reads zero
  function [8:0] cpsr_read;
    input [6:0] addr;
    begin
      case (addr)
        `CPSR_ADDR_POWER_ONE:    cpsr_read = power_reg_one;
        `CPSR_ADDR_POWER_TWO:    cpsr_read = power_two_reg;
        `CPSR_ADDR_POWER_THREE:  cpsr_read = power_three_reg;
        `CPSR_ADDR_CLOCK_CTRL:   cpsr_read = clock_ctrl_reg;
        `CPSR_ADDR_DAC_CTRL:     cpsr_read = dac_control_reg;
        `CPSR_ADDR_ADC_CTRL:     cpsr_read = adc_control_reg;
        `CPSR_ADDR_BOOST_CTRL:   cpsr_read = boost_ctrl_reg;
        `CPSR_ADDR_LOW_POWER:    cpsr_read = low_power_reg;
        `CPSR_ADDR_POWER_STATUS: cpsr_read = status_word;
        default:                 cpsr_read = 9'h000;
      endcase
    end
  endfunction

  assign sclk_rise    = ctl_sclk & ~sclk_last_reg & ~ctl_cs_n;
  assign sclk_fall    = ~ctl_sclk & sclk_last_reg & ~ctl_cs_n;
  assign write_word   = {wdata_reg[7:0], ctl_sdin};
  assign write_addr   = head_reg[6:0];
  assign write_now    = sclk_rise & ~head_reg[7] &
                        (bit_count_reg == (`CPSR_FRAME_BITS - 5'd1));
  assign ctl_sdout    = rdata_reg[8];
  assign ctl_sdout_oe = reading_reg & ~ctl_cs_n;

  // serial frame capture: read flag, address, then data msb first
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sclk_last_reg <= 1'b0;
      bit_count_reg <= 5'd0;
      head_reg      <= 8'h00;
      wdata_reg     <= 9'h000;
      rdata_reg     <= 9'h000;
      reading_reg   <= 1'b0;
    end
    else
    begin
      sclk_last_reg <= ctl_sclk;
      if (ctl_cs_n)
      begin
        // idle between frames
        bit_count_reg <= 5'd0;
        reading_reg   <= 1'b0;
      end
      else if (sclk_rise && bit_count_reg != `CPSR_FRAME_BITS)
      begin
        bit_count_reg <= bit_count_reg + 5'd1;
        if (bit_count_reg < `CPSR_HEAD_BITS)
          head_reg <= {head_reg[6:0], ctl_sdin};
        else
          wdata_reg <= write_word;
        if (bit_count_reg == (`CPSR_HEAD_BITS - 5'd1) && head_reg[6])
        begin
          // read frame: load the addressed register for shift-out
          reading_reg <= 1'b1;
          rdata_reg   <= cpsr_read({head_reg[5:0], ctl_sdin});
        end
      end
      else if (sclk_fall && reading_reg && bit_count_reg > `CPSR_HEAD_BITS)
        rdata_reg <= {rdata_reg[7:0], 1'b0};
    end
  end

  // register writes; any write to address zero restores all defaults
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      power_reg_one   <= `CPSR_RST_POWER_ONE;
      power_two_reg   <= `CPSR_RST_POWER_TWO;
      power_three_reg <= `CPSR_RST_POWER_THREE;
      clock_ctrl_reg  <= `CPSR_RST_CLOCK_CTRL;
      dac_control_reg <= `CPSR_RST_DAC_CTRL;
      adc_control_reg <= `CPSR_RST_ADC_CTRL;
      boost_ctrl_reg  <= `CPSR_RST_BOOST_CTRL;
      low_power_reg   <= `CPSR_RST_LOW_POWER;
    end
    else if (write_now)
    begin
      case (write_addr)
        `CPSR_ADDR_SOFT_RESET:
        begin
          power_reg_one   <= `CPSR_RST_POWER_ONE;
          power_two_reg   <= `CPSR_RST_POWER_TWO;
          power_three_reg <= `CPSR_RST_POWER_THREE;
          clock_ctrl_reg  <= `CPSR_RST_CLOCK_CTRL;
          dac_control_reg <= `CPSR_RST_DAC_CTRL;
          adc_control_reg <= `CPSR_RST_ADC_CTRL;
          boost_ctrl_reg  <= `CPSR_RST_BOOST_CTRL;
          low_power_reg   <= `CPSR_RST_LOW_POWER;
        end
        `CPSR_ADDR_POWER_ONE:   power_reg_one   <= write_word & `CPSR_MASK_POWER_ONE;
        `CPSR_ADDR_POWER_TWO:   power_two_reg   <= write_word & `CPSR_MASK_POWER_TWO;
        `CPSR_ADDR_POWER_THREE: power_three_reg <= write_word & `CPSR_MASK_POWER_THREE;
        `CPSR_ADDR_CLOCK_CTRL:  clock_ctrl_reg  <= write_word & `CPSR_MASK_CLOCK_CTRL;
        `CPSR_ADDR_DAC_CTRL:    dac_control_reg <= write_word & `CPSR_MASK_DAC_CTRL;
        `CPSR_ADDR_ADC_CTRL:    adc_control_reg <= write_word & `CPSR_MASK_ADC_CTRL;
        `CPSR_ADDR_BOOST_CTRL:  boost_ctrl_reg  <= write_word & `CPSR_MASK_BOOST_CTRL;
        `CPSR_ADDR_LOW_POWER:   low_power_reg   <= write_word & `CPSR_MASK_LOW_POWER;
        default:                low_power_reg   <= low_power_reg;
      endcase
    end
  end

  // outputs registered from the control fields
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ref_impedance_sel    <= 2'h0;
      master_bias_en       <= 1'b0;
      bias_buffer_en       <= 1'b0;
      mic_bias_en          <= 1'b0;
      aux_en               <= 1'b0;
      dc_buffer_en         <= 1'b0;
      pll_power_en         <= 1'b0;
      adc_power_en         <= 1'b0;
      pga_power_en         <= 1'b0;
      input_boost_en       <= 1'b0;
      dac_power_en         <= 1'b0;
      speaker_mixer_en     <= 1'b0;
      mono_mixer_en        <= 1'b0;
      speaker_pos_en       <= 1'b0;
      speaker_neg_en       <= 1'b0;
      mono_output_en       <= 1'b0;
      clock_io_master_en   <= 1'b0;
      bit_clock_div_sel    <= 3'h0;
      master_clock_div_sel <= 3'h0;
      dac_oversample_sel   <= 1'b0;
      adc_oversample_sel   <= 1'b0;
      dac_soft_mute        <= 1'b0;
      speaker_boost_mode   <= 1'b0;
      mono_out_boost_mode  <= 1'b0;
      low_power_bits       <= 9'h000;
    end
    else
    begin
      ref_impedance_sel    <= power_reg_one[`CPSR_REF_IMPEDANCE_SEL_LSB +: 2];
      master_bias_en       <= power_reg_one[`CPSR_MBIAS_BIT];
      bias_buffer_en       <= power_reg_one[`CPSR_BIASBUF_BIT];
      mic_bias_en          <= power_reg_one[`CPSR_MICBIAS_BIT];
      aux_en               <= power_reg_one[`CPSR_AUX_BIT];
      dc_buffer_en         <= power_reg_one[`CPSR_DCBUF_BIT];
      pll_power_en         <= power_reg_one[`CPSR_PLL_BIT];
      adc_power_en         <= power_two_reg[`CPSR_ADC_EN_BIT];
      pga_power_en         <= power_two_reg[`CPSR_PGA_EN_BIT];
      input_boost_en       <= power_two_reg[`CPSR_BOOSTSTG_EN_BIT];
      dac_power_en         <= power_three_reg[`CPSR_DAC_EN_BIT];
      speaker_mixer_en     <= power_three_reg[`CPSR_SPKMIX_BIT];
      mono_mixer_en        <= power_three_reg[`CPSR_MONOMIX_BIT];
      speaker_pos_en       <= power_three_reg[`CPSR_SPKPOS_BIT];
      speaker_neg_en       <= power_three_reg[`CPSR_SPKNEG_BIT];
      mono_output_en       <= power_three_reg[`CPSR_MONOOUT_BIT];
      clock_io_master_en   <= clock_ctrl_reg[`CPSR_CLKIO_BIT];
      bit_clock_div_sel    <= clock_ctrl_reg[`CPSR_BCLKDIV_LSB +: 3];
      master_clock_div_sel <= clock_ctrl_reg[`CPSR_MCLKDIV_LSB +: 3];
      dac_oversample_sel   <= dac_control_reg[`CPSR_OSR_BIT];
      adc_oversample_sel   <= adc_control_reg[`CPSR_OSR_BIT];
      dac_soft_mute        <= dac_control_reg[`CPSR_DAC_MUTE_BIT];
      speaker_boost_mode   <= boost_ctrl_reg[`CPSR_SPK_BOOST_BIT];
      mono_out_boost_mode  <= boost_ctrl_reg[`CPSR_MONO_BOOST_BIT];
      low_power_bits       <= low_power_reg;
    end
  end

endmodule
`default_nettype wire

// ==== test/cpsr_power_seq_checker.sv ====
// assertion checker watching the power sequencing register block ports
`timescale 1ns/100ps
`default_nettype none
module cpsr_power_seq_checker
(
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       ctl_sclk,
  input wire logic       ctl_cs_n,
  input wire logic       ctl_sdin,
  input wire logic [1:0] ref_impedance_sel,
  input wire logic       master_bias_en,
  input wire logic       bias_buffer_en,
  input wire logic       pll_power_en,
  input wire logic       adc_power_en,
  input wire logic       dac_power_en,
  input wire logic       speaker_mixer_en,
  input wire logic       mono_mixer_en,
  input wire logic       speaker_pos_en,
  input wire logic       speaker_neg_en,
  input wire logic       mono_output_en,
  input wire logic       dac_oversample_sel,
  input wire logic       adc_oversample_sel
);
  logic        sclk_q;   // control clock level one cycle ago
  logic [4:0]  rise_cnt; // control clock rises taken in this frame
  logic [16:0] frame_sh; // frame bits, read flag at the top
  logic        wr_done;  // a full frame was taken last edge
  wire  [6:0]  waddr = frame_sh[15:9];
  wire         wv    = wr_done && !frame_sh[16];
  // follow the serial frame the way the block takes it
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sclk_q   <= 1'b0;
      rise_cnt <= 5'h00;
      frame_sh <= 17'h00000;
      wr_done  <= 1'b0;
    end
    else
    begin
      sclk_q  <= ctl_sclk;
      wr_done <= !ctl_cs_n && ctl_sclk && !sclk_q && rise_cnt == 5'h10;
      if (ctl_cs_n)
        rise_cnt <= 5'h00;
      else if (ctl_sclk && !sclk_q && rise_cnt < 5'h11)
      begin
        rise_cnt <= rise_cnt + 5'h01;
        frame_sh <= {frame_sh[15:0], ctl_sdin};
      end
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_master_bias_write: assert property (wv && waddr == 7'h01 |=> master_bias_en == frame_sh[3])
    else $error("master bias enable does not follow the write");
  a_ref_sel_write: assert property (wv && waddr == 7'h01 |=> ref_impedance_sel == frame_sh[1:0])
    else $error("reference select does not follow the write");
  a_bias_buffer_write: assert property (wv && waddr == 7'h01 |=> bias_buffer_en == frame_sh[2])
    else $error("bias buffer enable does not follow the write");
  a_dac_osr_write: assert property (wv && waddr == 7'h0A |=> dac_oversample_sel == frame_sh[3])
    else $error("dac oversample select does not follow the write");
  a_adc_osr_write: assert property (wv && waddr == 7'h0E |=> adc_oversample_sel == frame_sh[3])
    else $error("adc oversample select does not follow the write");
  a_stage_enables: assert property (wv && waddr == 7'h03 |=> {mono_output_en, speaker_neg_en, speaker_pos_en, mono_mixer_en, speaker_mixer_en, dac_power_en} == {frame_sh[7:5], frame_sh[3:2], frame_sh[0]})
    else $error("stage enables do not follow the write");
  a_idle_enables: assert property (ctl_cs_n [*4] |-> $stable({master_bias_en, pll_power_en, adc_power_en, dac_power_en}))
    else $error("enable changed with no frame");
endmodule
bind cpsr_power_seq cpsr_power_seq_checker cpsr_power_seq_checker_i (.clk, .rst, .ctl_sclk,
  .ctl_cs_n, .ctl_sdin, .ref_impedance_sel, .master_bias_en, .bias_buffer_en, .pll_power_en,
  .adc_power_en, .dac_power_en, .speaker_mixer_en, .mono_mixer_en, .speaker_pos_en,
  .speaker_neg_en, .mono_output_en, .dac_oversample_sel, .adc_oversample_sel);
`default_nettype wire

// ==== test/cpsr_host_model.sv ====
// behavioural host driving the serial control port
`timescale 1ns/100ps
`default_nettype none
module cpsr_host_model
(
  input  wire logic clk,       // pacing clock
  output logic      ctl_sclk,  // serial clock, still between frames
  output logic      ctl_cs_n,  // frame select, active low
  output logic      ctl_sdin,  // serial data towards the block
  input  wire logic ctl_sdout  // readback bit
);
  initial
  begin
    ctl_sclk = 1'b0;
    ctl_cs_n = 1'b1;
    ctl_sdin = 1'b1;
  end
  // one frame of flag, address and data; each clock phase lasts two cycles
  task automatic frame(input logic rd, input logic [6:0] a, input logic [8:0] d,
                       output logic [8:0] q);
    logic [16:0] f;
    f = {rd, a, d};
    q = 9'h000;
    @(negedge clk);
    ctl_cs_n = 1'b0;
    for (int i = 16; i >= 0; i--)
    begin
      ctl_sdin = f[i];
      repeat (2) @(negedge clk);
      if (rd && i < 9)
        q[i] = ctl_sdout; // readback bit taken as the clock rises
      ctl_sclk = 1'b1;
      repeat (2) @(negedge clk);
      ctl_sclk = 1'b0;
    end
    repeat (2) @(negedge clk);
    ctl_cs_n = 1'b1;
    ctl_sdin = ~ctl_sdin; // released line never shows the stale bit
    repeat (2) @(negedge clk);
  endtask
endmodule
`default_nettype wire

// ==== test/cpsr_power_seq_tb.sv ====
// self-checking bench for the power sequencing registers
`timescale 1ns/100ps
`default_nettype none
module cpsr_power_seq_tb;
  logic       clk;
  logic       rst;
  wire  [1:0] ref_impedance_sel;
  wire  [2:0] bit_clock_div_sel, master_clock_div_sel;
  wire  [8:0] low_power_bits;
  wire        master_bias_en, bias_buffer_en, mic_bias_en, aux_en, dc_buffer_en, pll_power_en,
              adc_power_en, pga_power_en, input_boost_en, dac_power_en, speaker_mixer_en,
              mono_mixer_en, speaker_pos_en, speaker_neg_en, mono_output_en, clock_io_master_en,
              dac_oversample_sel, adc_oversample_sel, dac_soft_mute, speaker_boost_mode,
              mono_out_boost_mode, ctl_sclk, ctl_cs_n, ctl_sdin, ctl_sdout, ctl_sdout_oe;
  int         miscompares = 0;
  int         n_checks = 0;
  int         oe_cycles = 0; // clocks with the readback drive seen on
  // outputs regrouped in register bit order; v_misc packs the boost, mute and oversample outputs
  wire  [8:0] v_pwr1 = {dc_buffer_en, 1'b0, aux_en, pll_power_en, mic_bias_en, master_bias_en,
                        bias_buffer_en, ref_impedance_sel};
  wire  [8:0] v_pwr3 = {1'b0, mono_output_en, speaker_neg_en, speaker_pos_en, 1'b0,
                        mono_mixer_en, speaker_mixer_en, 1'b0, dac_power_en};
  wire  [8:0] v_pwr2 = {4'h0, input_boost_en, 1'b0, pga_power_en, 1'b0, adc_power_en};
  wire  [8:0] v_clk  = {1'b0, master_clock_div_sel, bit_clock_div_sel, 1'b0, clock_io_master_en};
  wire  [8:0] v_misc = {4'h0, speaker_boost_mode, mono_out_boost_mode, dac_soft_mute,
                        dac_oversample_sel, adc_oversample_sel};
  cpsr_power_seq cpsr_power_seq_i (.clk(clk), .rst(rst), .ctl_sclk(ctl_sclk), .ctl_cs_n(ctl_cs_n),
    .ctl_sdin(ctl_sdin), .ctl_sdout(ctl_sdout), .ctl_sdout_oe(ctl_sdout_oe),
    .ref_impedance_sel(ref_impedance_sel), .master_bias_en(master_bias_en),
    .bias_buffer_en(bias_buffer_en), .mic_bias_en(mic_bias_en), .aux_en(aux_en),
    .dc_buffer_en(dc_buffer_en), .pll_power_en(pll_power_en), .adc_power_en(adc_power_en),
    .pga_power_en(pga_power_en), .input_boost_en(input_boost_en), .dac_power_en(dac_power_en),
    .speaker_mixer_en(speaker_mixer_en), .mono_mixer_en(mono_mixer_en),
    .speaker_pos_en(speaker_pos_en), .speaker_neg_en(speaker_neg_en),
    .mono_output_en(mono_output_en), .clock_io_master_en(clock_io_master_en),
    .bit_clock_div_sel(bit_clock_div_sel), .master_clock_div_sel(master_clock_div_sel),
    .dac_oversample_sel(dac_oversample_sel), .adc_oversample_sel(adc_oversample_sel),
    .dac_soft_mute(dac_soft_mute), .speaker_boost_mode(speaker_boost_mode),
    .mono_out_boost_mode(mono_out_boost_mode), .low_power_bits(low_power_bits));
  // count clocks on which the readback line is driven
  always @(posedge clk)
    if (ctl_sdout_oe === 1'b1)
      oe_cycles <= oe_cycles + 1;
  cpsr_host_model cpsr_host_model_i (.clk(clk), .ctl_sclk(ctl_sclk), .ctl_cs_n(ctl_cs_n),
                                     .ctl_sdin(ctl_sdin), .ctl_sdout(ctl_sdout));
  // free running 40 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task chk(input string n, input logic [8:0] e, input logic [8:0] g);
    n_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task wr(input logic [6:0] a, input logic [8:0] d);
    logic [8:0] q;
    int         c0;
    c0 = oe_cycles;
    cpsr_host_model_i.frame(1'b0, a, d, q);
    chk("write oe", 9'h000, {8'h00, oe_cycles != c0});
  endtask
  task rd(input logic [6:0] a, input logic [8:0] e, input string n);
    logic [8:0] q;
    int         c0;
    c0 = oe_cycles;
    cpsr_host_model_i.frame(1'b1, a, 9'h000, q);
    chk(n, e, q);
    chk("read oe", 9'h001, {8'h00, oe_cycles != c0});
    chk("oe off", 9'h000, {8'h00, ctl_sdout_oe});
  endtask
  task end_sim;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // defaults straight out of reset
  task t_reset;
    chk("pwr1 out", 9'h000, v_pwr1);
    chk("clock out", 9'h040, v_clk);
    chk("mode out", 9'h000, v_misc);
    rd(7'h01, 9'h000, "pwr1 read");
    rd(7'h0A, 9'h000, "dac read");
    rd(7'h0E, 9'h100, "adc read");
    rd(7'h3A, 9'h000, "lowpwr read");
  endtask
  // host power-up order for 5.0 V supply
  task t_power_up;
    // gain stages stay at default, no volume step needs a zero-cross
    wr(7'h2F, 9'h00C);
    chk("boost", 9'h018, v_misc);
    wr(7'h0A, 9'h040);
    chk("muted", 9'h01C, v_misc);
    wr(7'h01, 9'h00E);
    chk("pwr1 bias", 9'h00E, v_pwr1);
    wr(7'h06, 9'h0A9);
    chk("clock", 9'h0A9, v_clk);
    wr(7'h01, 9'h02E);
    chk("pll", 9'h02E, v_pwr1);
    wr(7'h03, 9'h001);
    wr(7'h02, 9'h001);
    chk("adc en", 9'h001, v_pwr2);
    wr(7'h03, 9'h00D);
    wr(7'h03, 9'h0ED);
    chk("stages", 9'h0ED, v_pwr3);
    wr(7'h0A, 9'h000);
    chk("unmute", 9'h018, v_misc);
  endtask
  // oversample selects both ways
  task t_osr;
    wr(7'h0A, 9'h048);
    chk("dac osr", 9'h01E, v_misc);
    wr(7'h0E, 9'h108);
    chk("adc osr", 9'h01F, v_misc);
    rd(7'h0E, 9'h108, "adc read");
    wr(7'h0E, 9'h100);
    wr(7'h0A, 9'h000);
    chk("osr low", 9'h018, v_misc);
  endtask
  // every reference select code
  task t_ref;
    for (int k = 0; k < 4; k++)
    begin
      wr(7'h01, 9'h008 | 9'(k));
      chk("ref sel", 9'h008 | 9'(k), v_pwr1);
    end
  endtask
  // host power-down order, then speaker boost modes off
  task t_power_down;
    wr(7'h0A, 9'h040);
    wr(7'h01, 9'h000);
    chk("pwr1 off", 9'h000, v_pwr1);
    chk("stages kept", 9'h0ED, v_pwr3);
    wr(7'h03, 9'h000);
    chk("stages off", 9'h000, v_pwr3);
    wr(7'h2F, 9'h000);
    chk("boost off", 9'h004, v_misc);
  endtask
  // low power register, unmapped and read-only places
  task t_misc;
    wr(7'h3A, 9'h1FF);
    chk("lowpwr out", 9'h1FF, low_power_bits);
    rd(7'h3A, 9'h1FF, "lowpwr read");
    wr(7'h07, 9'h1FF);
    wr(7'h2E, 9'h1FF);
    chk("pwr1 kept", 9'h000, v_pwr1);
    rd(7'h2E, 9'h000, "status read");
    wr(7'h01, 9'h1FF);
    chk("pwr1 all", 9'h17F, v_pwr1);
    rd(7'h2E, 9'h10F, "status on");
    wr(7'h02, 9'h1FF);
    chk("pwr2 all", 9'h015, v_pwr2);
    wr(7'h00, 9'h000);
    chk("soft pwr1", 9'h000, v_pwr1);
    chk("soft pwr2", 9'h000, v_pwr2);
    chk("soft clock", 9'h040, v_clk);
    chk("soft lowpwr", 9'h000, low_power_bits);
    rd(7'h0E, 9'h100, "soft adc");
  endtask
  // watchdog cuts a hang short
  initial
  begin
    repeat (20000) @(posedge clk);
    miscompares++;
    end_sim();
  end
  // main sequence
  initial
  begin
    rst = 1'b1;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    // outputs follow the register defaults one clock after release
    repeat (2) @(negedge clk);
    t_reset();
    t_power_up();
    t_osr();
    t_ref();
    t_power_down();
    t_misc();
    end_sim();
  end
endmodule
`default_nettype wire
